//--- mcps_ontime.sv
/*
 * On-time timer: one high-side pulse per start, width from nominal and current trims.
 * Assumes trim inputs are two's complement and stable during a pulse.
 */
`timescale 1ns/1ps
module mcps_ontime
	import mcps_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic kill,
	input wire logic [TON_W-1:0] ton_nom,
	input wire logic signed [TON_W-1:0] trim_phase,
	input wire logic signed [TON_W-1:0] trim_total,
	output logic active
);
	typedef struct packed {
		logic [TON_W-1:0] cnt;
	} mcps_ton_st_t;

	mcps_ton_st_t s_q, s_d;
	logic signed [TON_W+1:0] width;

	always_comb begin
		s_d = s_q;
		width = $signed({2'b00, ton_nom}) + trim_phase + trim_total;
		if (width < $signed({2'b00, TON_MIN})) begin
			width = $signed({2'b00, TON_MIN});
		end
		if (kill) begin
			s_d.cnt = '0;
		end else if (start) begin
			s_d.cnt = width[TON_W-1:0];
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 12'h001;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign active = (s_q.cnt != '0);
endmodule : mcps_ontime

//--- mcps_phase.sv
/*
 * One phase of the multiphase constant-on-time converter: role detect, token ring,
 * fire generation, mode, shedding, soft start, pre-bias, discharge sequencing.
 * Assumes comparator results and bus write/read strobes synchronous to mclk.
 */
`timescale 1ns/1ps
module mcps_phase
	import mcps_pkg::*;
(
	// -------------------------------------------------
	// Clock, reset and ring
	// -------------------------------------------------
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic token_in,
	input wire logic fire_in,

	// -------------------------------------------------
	// Comparators and faults
	// -------------------------------------------------
	input wire logic fb_ramp_below_comp,
	input wire logic fb_above_ref,
	input wire logic fb_below_disch,
	input wire logic bootstrap_low,
	input wire logic ov_fault,
	input wire logic uv_fault,
	input wire logic ot_fault,
	input wire logic shared_fault_line_in,

	// -------------------------------------------------
	// Configuration
	// -------------------------------------------------
	input wire logic enable,
	input wire logic shed_pin_n,
	input wire logic shed_bit,
	input wire logic shed_src,
	input wire logic continuous_conduction,
	input wire logic ramp_reset_sel,
	input wire logic [RAMP_W-1:0] ramp_sel,
	input wire logic [SS_W-1:0] soft_start_time_cmd,
	input wire logic discharge_en,
	input wire logic zero_cross,

	// -------------------------------------------------
	// On-time and bus
	// -------------------------------------------------
	input wire logic [TON_W-1:0] ton_nom,
	input wire logic signed [TON_W-1:0] trim_phase,
	input wire logic signed [TON_W-1:0] trim_total,
	input wire logic bus_wr,
	input wire logic bus_rd,

	// -------------------------------------------------
	// Outputs
	// -------------------------------------------------
	output logic is_master,
	output logic fire_out,
	output logic token_out,
	output logic high_side_switch,
	output logic low_side_switch,
	output logic discharge_switch,
	output logic shared_fault_line_oe,
	output logic slave_fault,
	output logic soft_start_active,
	output logic ramp_rising,
	output logic [RAMP_W-1:0] ramp_amp,
	output logic bus_wr_ack,
	output logic bus_rd_ack
);

	// -------------------------------------------------
	// State
	// -------------------------------------------------
	typedef struct packed {
		mcps_state_t st;
		logic decided;
		logic master;
		logic token_d1;
		logic grant;
		logic fire;
		logic [7:0] gap;
		logic [7:0] tok;
		logic tok_out;
		logic [7:0] boot;
		logic ls;
		logic hs;
		logic disch;
		logic [CNT_W-1:0] ss_cnt;
		logic ss;
		logic first_done;
		logic flt_oe;
		logic slv_flt;
		logic wr_ack;
		logic rd_ack;
	} mcps_phase_st_t;

	mcps_phase_st_t s_q, s_d;
	logic ton_active;
	logic ton_start;
	logic ton_kill;
	logic shed;
	logic fire_seen;
	logic fire_req;
	logic [CNT_W-1:0] ss_len;

	// -------------------------------------------------
	// Helpers
	// -------------------------------------------------
	function automatic logic [CNT_W-1:0] ss_cycles(input logic [SS_W-1:0] code);
		logic [SS_W-1:0] c;
		c = (code > SS_W'(SS_CODE_MAX)) ? SS_W'(SS_CODE_MAX) : code;
		return CNT_W'(SS_BASE_CYC) << c;
	endfunction : ss_cycles

	// Pulses only while soft start or regulation runs
	function automatic logic switching_state(input mcps_state_t st);
		return (st == MCPS_SOFT) || (st == MCPS_RUN);
	endfunction : switching_state

	// Both switches latched off here
	function automatic logic quiet_state(input mcps_state_t st);
		return (st == MCPS_OFF) || (st == MCPS_DISCHARGE);
	endfunction : quiet_state

	// Master never sheds, whatever either control says
	function automatic logic slave_shed(input logic master, input logic src,
		input logic pin_n, input logic bit_set);
		return !master && (src ? !pin_n : bit_set);
	endfunction : slave_shed

	// -------------------------------------------------
	// Submodules
	// -------------------------------------------------
	mcps_ramp u_ramp (
		.mclk(mclk),
		.reset_n(reset_n),
		.enable(s_q.master && s_q.st != MCPS_OFF),
		.reset_on_fire(ramp_reset_sel),
		.fire(s_q.fire),
		.hs_on(ton_start),
		.amp_sel(ramp_sel),
		.ramp_rising(ramp_rising),
		.ramp_amp(ramp_amp)
	);

	mcps_ontime u_ton (
		.mclk(mclk),
		.reset_n(reset_n),
		.start(ton_start),
		.kill(ton_kill),
		.ton_nom(ton_nom),
		.trim_phase(trim_phase),
		.trim_total(trim_total),
		.active(ton_active)
	);

	// -------------------------------------------------
	// Next state
	// -------------------------------------------------
	always_comb begin
		s_d = s_q;
		ss_len = ss_cycles(soft_start_time_cmd);
		shed = slave_shed(s_q.master, shed_src, shed_pin_n, shed_bit);
		fire_seen = s_q.master ? s_q.fire : fire_in;
		fire_req = 1'b0;
		ton_kill = quiet_state(s_q.st) || shed;
		ton_start = 1'b0;

		// Role detect once after reset: token held high means master
		if (!s_q.decided) begin
			s_d.decided = 1'b1;
			s_d.master = token_in;
		end

		// Token input falling edge grants the turn
		s_d.token_d1 = token_in;
		if (s_q.decided && s_q.token_d1 && !token_in && !shed) begin
			s_d.grant = 1'b1;
		end

		// Fire generation in master only, minimum spacing
		if (s_q.gap != '0) begin
			s_d.gap = s_q.gap - 8'h01;
		end
		if (s_q.master && s_q.gap == '0 && fb_ramp_below_comp
			&& switching_state(s_q.st)) begin
			fire_req = 1'b1;
		end
		s_d.fire = fire_req;
		if (fire_req) begin
			s_d.gap = FIRE_GAP;
		end

		// First pulse of system belongs to master with no grant yet
		if (s_q.master && !s_q.first_done && s_q.st == MCPS_SOFT) begin
			s_d.grant = 1'b1;
			s_d.first_done = 1'b1;
		end

		// Granted phase acts on one fire
		if (fire_seen && s_q.grant && !ton_kill && !ton_active) begin
			ton_start = 1'b1;
			s_d.grant = 1'b0;
			s_d.tok = TOKEN_CNT;
		end
		if (shed) begin
			s_d.grant = 1'b0;
		end
		if (s_q.tok != '0 && !ton_start) begin
			s_d.tok = s_q.tok - 8'h01;
		end
		s_d.tok_out = ton_start || (s_q.tok > 8'h01);

		// Sequencing of start-up and shutdown
		if (s_q.boot != '0) begin
			s_d.boot = s_q.boot - 8'h01;
		end
		case (s_q.st)
			MCPS_OFF: begin
				s_d.first_done = 1'b0;
				if (enable && s_q.decided) begin
					s_d.st = MCPS_PREBIAS;
				end
			end
			MCPS_PREBIAS: begin
				if (bootstrap_low && s_q.boot == '0 && !s_q.ls) begin
					s_d.boot = BOOT_ON;
				end
				if (fb_above_ref && s_q.boot == '0) begin
					s_d.st = MCPS_SOFT;
					s_d.ss_cnt = ss_len;
				end
			end
			MCPS_SOFT: begin
				if (s_q.ss_cnt != '0) begin
					s_d.ss_cnt = s_q.ss_cnt - 24'h000001;
				end else begin
					s_d.st = MCPS_RUN;
				end
			end
			MCPS_RUN: begin
			end
			MCPS_DISCHARGE: begin
				if (fb_below_disch || enable) begin
					s_d.st = MCPS_OFF;
				end
			end
			default: begin
				s_d.st = MCPS_OFF;
			end
		endcase
		if (!enable && !quiet_state(s_q.st)) begin
			s_d.st = discharge_en ? MCPS_DISCHARGE : MCPS_OFF;
			s_d.grant = 1'b0;
		end
		s_d.ss = (s_d.st == MCPS_SOFT);

		// Switch drive: pre-bias keeps both off except bootstrap refresh
		// Next state decides, so a disable never leaves the high side on
		s_d.hs = (ton_start || ton_active) && !ton_kill
			&& switching_state(s_d.st);
		case (s_d.st)
			MCPS_PREBIAS: s_d.ls = (s_d.boot != '0);
			MCPS_SOFT, MCPS_RUN: s_d.ls = !s_d.hs && !shed
				&& (continuous_conduction || !zero_cross);
			default: s_d.ls = 1'b0;
		endcase
		s_d.disch = (s_d.st == MCPS_DISCHARGE);

		// Fault signalling: slaves pull shared line, master watches it
		s_d.flt_oe = !s_q.master && s_q.decided && (ov_fault || uv_fault || ot_fault);
		s_d.slv_flt = s_q.master && shared_fault_line_in;

		// Management bus acceptance
		s_d.wr_ack = bus_wr && s_q.decided;
		s_d.rd_ack = bus_rd && s_q.decided && s_q.master;
	end

	// -------------------------------------------------
	// Registers
	// -------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '{st: MCPS_OFF, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// -------------------------------------------------
	// Outputs
	// -------------------------------------------------
	assign is_master = s_q.master;
	assign fire_out = s_q.fire;
	assign token_out = s_q.tok_out;
	assign high_side_switch = s_q.hs;
	assign low_side_switch = s_q.ls;
	assign discharge_switch = s_q.disch;
	assign shared_fault_line_oe = s_q.flt_oe;
	assign slave_fault = s_q.slv_flt;
	assign soft_start_active = s_q.ss;
	assign bus_wr_ack = s_q.wr_ack;
	assign bus_rd_ack = s_q.rd_ack;
endmodule : mcps_phase

//--- mcps_phase_sva.sv
/*
 * Port checker for one converter phase.
 * Assumes it is bound to mcps_phase and sees its ports only.
 */
`timescale 1ns/1ps
module mcps_phase_sva (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic bus_wr,
	input wire logic shared_fault_line_in,
	input wire logic is_master,
	input wire logic fire_out,
	input wire logic token_out,
	input wire logic high_side_switch,
	input wire logic low_side_switch,
	input wire logic discharge_switch,
	input wire logic shared_fault_line_oe,
	input wire logic slave_fault,
	input wire logic bus_wr_ack,
	input wire logic bus_rd_ack
);
	// ---------------------------------------------
	// Properties
	// ---------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence tok_pulse;
		token_out [*4] ##1 !token_out;
	endsequence
	chk_role_hold: assert property (is_master |=> is_master)
		else $error("role changed");
	chk_rd_master: assert property (bus_rd_ack |-> is_master)
		else $error("read answered by slave");
	chk_wr_ack: assert property (bus_wr |=> bus_wr_ack)
		else $error("write not answered");
	chk_fire_master: assert property (fire_out |-> is_master)
		else $error("slave fired");
	chk_fault_mirror: assert property (is_master && shared_fault_line_in |=> slave_fault)
		else $error("slave fault missed");
	chk_fault_oe: assert property (shared_fault_line_oe |-> !is_master)
		else $error("master drives fault line");
	chk_hs_token: assert property ($rose(high_side_switch) |-> $rose(token_out))
		else $error("token not with switch");
	chk_token_width: assert property ($rose(token_out) |-> tok_pulse)
		else $error("token width wrong");
	chk_fire_gap: assert property (fire_out |=> !fire_out)
		else $error("fire requests too close");
	chk_disch_off: assert property (discharge_switch |-> !high_side_switch && !low_side_switch)
		else $error("switch on while discharging");
endmodule : mcps_phase_sva

bind mcps_phase mcps_phase_sva mcps_phase_sva_i (.mclk, .reset_n, .bus_wr,
	.shared_fault_line_in, .is_master, .fire_out, .token_out, .high_side_switch,
	.low_side_switch, .discharge_switch, .shared_fault_line_oe, .slave_fault,
	.bus_wr_ack, .bus_rd_ack);

//--- mcps_phase_tb.sv
/*
 * Self-checking bench for mcps_phase: slave shedding table, then master cases.
 * Assumes mcps_ring_model closes the ring and the checker is bound.
 */
`timescale 1ns/1ps
module mcps_phase_tb;
	import mcps_pkg::*;
	logic mclk, reset_n, token_in, fire_in, fb_ramp_below_comp, fb_above_ref, fb_below_disch;
	logic bootstrap_low, ov_fault, uv_fault, ot_fault, shared_fault_line_in, enable;
	logic shed_pin_n, shed_bit, shed_src, continuous_conduction, ramp_reset_sel, discharge_en;
	logic zero_cross, bus_wr, bus_rd, master_tie, kick, m;
	logic [RAMP_W-1:0] ramp_sel, ramp_amp;
	logic [SS_W-1:0] soft_start_time_cmd;
	logic [TON_W-1:0] ton_nom;
	logic signed [TON_W-1:0] trim_phase, trim_total;
	logic is_master, fire_out, token_out, high_side_switch, low_side_switch, discharge_switch;
	logic shared_fault_line_oe, slave_fault, soft_start_active, ramp_rising;
	logic bus_wr_ack, bus_rd_ack;
	int failures, samples_checked, n;
	// Rows: {shed_src, shed_bit, shed_pin_n, slave switches}
	logic [3:0] rows [8] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h8, 4'hb, 4'hc, 4'hf};
	mcps_phase mcps_phase_i (.mclk, .reset_n, .token_in, .fire_in, .fb_ramp_below_comp,
		.fb_above_ref, .fb_below_disch, .bootstrap_low, .ov_fault, .uv_fault, .ot_fault,
		.shared_fault_line_in, .enable, .shed_pin_n, .shed_bit, .shed_src,
		.continuous_conduction, .ramp_reset_sel, .ramp_sel, .soft_start_time_cmd,
		.discharge_en, .zero_cross, .ton_nom, .trim_phase, .trim_total, .bus_wr, .bus_rd,
		.is_master, .fire_out, .token_out, .high_side_switch, .low_side_switch,
		.discharge_switch, .shared_fault_line_oe, .slave_fault, .soft_start_active,
		.ramp_rising, .ramp_amp, .bus_wr_ack, .bus_rd_ack);
	mcps_ring_model mcps_ring_model_i (.mclk, .reset_n, .master_tie, .kick, .token_out,
		.token_in);
	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask : cyc
	task automatic chk_bit(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic chk_cnt(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_cnt
	task automatic do_reset(input logic mst);
		reset_n <= 1'b0;
		master_tie <= mst;
		cyc(4);
		reset_n <= 1'b1;
		#1 chk_bit("reset outputs", 1'b0, |{high_side_switch, token_out, fire_out, is_master});
		cyc(3);
	endtask : do_reset
	// One-cycle request; caller looks two edges after it was taken
	task automatic fire(input logic mst);
		fb_ramp_below_comp <= mst;
		fire_in <= !mst;
		cyc(1);
		fb_ramp_below_comp <= 1'b0;
		fire_in <= 1'b0;
		cyc(2);
	endtask : fire
	task automatic bus(input logic rd, input logic exp);
		bus_wr <= !rd;
		bus_rd <= rd;
		cyc(1);
		bus_wr <= 1'b0;
		bus_rd <= 1'b0;
		#1 chk_bit("bus ack", exp, rd ? bus_rd_ack : bus_wr_ack);
		cyc(1);
	endtask : bus
	task automatic wrap_up;
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	// ---------------------------------------------
	// Tests
	// ---------------------------------------------
	initial begin
		cyc(3000);
		failures++;
		wrap_up();
	end
	initial begin
		{fire_in, fb_ramp_below_comp, fb_below_disch, bootstrap_low, ov_fault, uv_fault} = '0;
		{ot_fault, shared_fault_line_in, bus_wr, bus_rd, kick, master_tie, reset_n} = '0;
		{shed_bit, shed_src, zero_cross, continuous_conduction, ramp_reset_sel} = '0;
		{enable, shed_pin_n, discharge_en, fb_above_ref} = '1;
		ramp_sel = 3'h5;
		soft_start_time_cmd = 3'h0;
		ton_nom = 12'h005;
		trim_phase = 12'hfff;
		trim_total = 12'h000;
		do_reset(1'b0);
		foreach (rows[i]) begin
			{shed_src, shed_bit, shed_pin_n} <= rows[i][3:1];
			{continuous_conduction, ramp_reset_sel} <= rows[i][2:1];
			kick <= 1'b1;
			cyc(1);
			kick <= 1'b0;
			cyc(2);
			fire(1'b0);
			#1 chk_bit("slave switch", rows[i][0], high_side_switch);
			chk_bit("slave token", rows[i][0], token_out);
			chk_bit("slave fire", 1'b0, fire_out);
			chk_bit("slave ramp", 1'b0, ramp_rising);
			cyc(10);
		end
		bus(1'b1, 1'b0);
		bus(1'b0, 1'b1);
		for (int j = 0; j < 3; j++) begin
			{ov_fault, uv_fault, ot_fault} <= 3'h1 << j;
			cyc(3);
			#1 chk_bit("fault line", 1'b1, shared_fault_line_oe);
			cyc(1);
		end
		{ov_fault, uv_fault, ot_fault, fb_above_ref} <= '0;
		// Both shedding sources ask to shed; the master must ignore them
		{shed_bit, shed_pin_n} <= 2'h2;
		do_reset(1'b1);
		chk_bit("role", 1'b1, is_master);
		// Comparator held low-side of compensation: must not fire before reference passes
		bootstrap_low <= 1'b1;
		fb_ramp_below_comp <= 1'b1;
		cyc(1);
		bootstrap_low <= 1'b0;
		n = 0;
		m = 1'b0;
		repeat (20) begin
			#1 n += int'(low_side_switch);
			m |= high_side_switch;
			cyc(1);
		end
		chk_cnt("boot low side", 8'h08, 8'(n));
		chk_bit("prebias high side", 1'b0, m);
		fb_ramp_below_comp <= 1'b0;
		fb_above_ref <= 1'b1;
		cyc(3);
		fire(1'b1);
		#1 chk_bit("first pulse", 1'b1, high_side_switch);
		chk_bit("master token", 1'b1, token_out);
		chk_bit("ramp rising", 1'b1, ramp_rising);
		chk_bit("soft start", 1'b1, soft_start_active);
		chk_cnt("ramp amp", 8'h05, 8'(ramp_amp));
		cyc(3);
		fire(1'b1);
		#1 chk_bit("no grant", 1'b0, high_side_switch);
		cyc(12);
		fire(1'b1);
		#1 chk_bit("ring grant", 1'b1, high_side_switch);
		cyc(8);
		bus(1'b1, 1'b1);
		shared_fault_line_in <= 1'b1;
		cyc(2);
		#1 chk_bit("slave fault", 1'b1, slave_fault);
		chk_bit("ramp fall", 1'b0, ramp_rising);
		cyc(1);
		{zero_cross, continuous_conduction} <= 2'h2;
		cyc(2);
		#1 chk_bit("pulse skip", 1'b0, low_side_switch);
		cyc(1);
		continuous_conduction <= 1'b1;
		cyc(2);
		#1 chk_bit("forced conduction", 1'b1, low_side_switch);
		cyc(1);
		enable <= 1'b0;
		cyc(3);
		#1 chk_bit("discharge on", 1'b1, discharge_switch);
		chk_bit("soft start off", 1'b0, soft_start_active);
		cyc(1);
		fb_below_disch <= 1'b1;
		cyc(3);
		#1 chk_bit("discharge off", 1'b0, discharge_switch);
		wrap_up();
	end
endmodule : mcps_phase_tb

//--- mcps_pkg.sv
/*
 * Shared constants and types of the multiphase constant-on-time phase sequencer.
 * Assumes a single 40 MHz clock (mclk) and analog comparator results as synchronous inputs.
 */
package mcps_pkg;
	localparam int CLK_MHZ = 40;
	localparam int FIRE_GAP_NS = 50;
	localparam int FIRE_GAP_CYC = (FIRE_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int BOOT_ON_NS = 200;
	localparam int BOOT_ON_CYC = (BOOT_ON_NS * CLK_MHZ) / 1000;
	localparam int TOKEN_NS = 100;
	localparam int TOKEN_CYC = (TOKEN_NS * CLK_MHZ) / 1000;
	localparam int SS_BASE_MS = 1;
	localparam int SS_BASE_CYC = SS_BASE_MS * CLK_MHZ * 1000;
	localparam int RAMP_RISE_CYC = 8;
	localparam int SS_CODE_MAX = 4;
	localparam int TON_W = 12;
	localparam int RAMP_W = 3;
	localparam int SS_W = 3;
	localparam int CNT_W = 24;
	localparam logic [7:0] TOKEN_CNT = 8'(TOKEN_CYC);
	localparam logic [7:0] FIRE_GAP = 8'(FIRE_GAP_CYC);
	localparam logic [7:0] BOOT_ON = 8'(BOOT_ON_CYC);
	localparam logic [7:0] RAMP_RISE = 8'(RAMP_RISE_CYC);
	localparam logic [TON_W-1:0] TON_MIN = 12'h004;

	typedef enum logic [2:0] {
		MCPS_OFF,
		MCPS_PREBIAS,
		MCPS_SOFT,
		MCPS_RUN,
		MCPS_DISCHARGE
	} mcps_state_t;
endpackage : mcps_pkg

//--- mcps_ramp.sv
/*
 * Ramp compensation timing for the master phase: fixed rise window, then discharge until the next trigger.
 * Assumes the analog ramp follows ramp_rising and ramp_amp; fire comparison is external.
 */
`timescale 1ns/1ps
module mcps_ramp
	import mcps_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic reset_on_fire,
	input wire logic fire,
	input wire logic hs_on,
	input wire logic [RAMP_W-1:0] amp_sel,
	output logic ramp_rising,
	output logic [RAMP_W-1:0] ramp_amp
);
	typedef struct packed {
		logic [7:0] cnt;
		logic rising;
		logic [RAMP_W-1:0] amp;
	} mcps_ramp_st_t;

	mcps_ramp_st_t s_q, s_d;
	logic trig;

	always_comb begin
		s_d = s_q;
		trig = reset_on_fire ? fire : hs_on;
		s_d.amp = amp_sel;
		if (!enable) begin
			s_d.rising = 1'b0;
			s_d.cnt = '0;
		end else if (trig) begin
			s_d.rising = 1'b1;
			s_d.cnt = RAMP_RISE;
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 8'h01;
			s_d.rising = (s_q.cnt != 8'h01);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ramp_rising = s_q.rising;
	assign ramp_amp = s_q.amp;
endmodule : mcps_ramp

//--- mcps_ring_model.sv
/*
 * Rest of the token ring seen from one phase.
 * Assumes a master token input held high until the first token returns, a bench kick for a slave.
 */
`timescale 1ns/1ps
module mcps_ring_model (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic master_tie,
	input wire logic kick,
	input wire logic token_out,
	output logic token_in
);
	typedef struct packed {
		logic seen;
		logic [11:0] dly;
	} mcps_ring_t;
	mcps_ring_t st_q;
	mcps_ring_t st_d;
	always_comb begin
		st_d = st_q;
		st_d.dly = {st_q.dly[10:0], token_out};
		st_d.seen = st_q.seen | st_q.dly[11];
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	// With master_tie, pulled high until the first token comes round, delay stands for other phases; else follows kick
	assign token_in = master_tie ? (!st_q.seen | st_q.dly[11]) : kick;
endmodule : mcps_ring_model
